/* core/mdsp_device.sv */
// Purpose: device end of the serial control port
// Assumes: sclk, ce_n, mosi and the reset pin are asynchronous and synchronised here
// Notes:   link edges found by sampling; sclk must be well below half of i_clock
`timescale 1ns/100ps
// Overview of operation
// [RULE1] ce high: reload output frame each edge
// [RULE2] ce low: shift miso msb first
// [RULE3] host ignores bits after sixteen
// [RULE4] ce low: sample mosi msb first
// [RULE5] sixteenth edge writes word to register
// [RULE6] last bit picks config or normal
// [RULE7] host holds mosi low when idle
// [RULE8] host gives one edge before frame
// [RULE9] host runs sclk continuously
// [RULE10] previous frame selects fault or conversion
// [RULE11] two frame types, both carry encoder
// [RULE12] reset pin input clears, safes, tristates
// [RULE13] pull reset low on faults
// [RULE14] bridge direction bit, switching follows pulse
// [RULE15] gate drive only when enabled
// [RULE16] both shifters advance same edge
// [RULE17] normal holds drive bits, config setup
// [RULE18] host sclk at most 16 MHz
// [RULE19] short frame discarded, registers unchanged
module mdsp_device
  import mdsp_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  mdsp_link_if.device      link,
  input  wire logic [7:0]  i_conv_result,
  input  wire logic [3:0]  i_encoder,
  input  wire logic [3:0]  i_fault_flags,
  input  wire logic        i_supply_undervoltage_lockout,
  input  wire logic        i_reg_undervoltage_lockout,
  input  wire logic        i_current_limit,
  input  wire logic        i_thermal_shutdown,
  input  wire logic        bridge_a_pulse_in,
  input  wire logic        bridge_b_pulse_in,
  input  wire logic        driver_c_pulse_in_a,
  input  wire logic        driver_c_pulse_in_b,
  output logic [1:0]       o_bridge_a,
  output logic [1:0]       o_bridge_b,
  output logic [1:0]       o_driver_c,
  output logic             o_low_side_hold,
  output logic             o_gate_drive,
  output logic [15:0]      o_normal,
  output logic [15:0]      o_config
);
  logic [2:0]       sclk_s;
  logic [1:0]       ce_s;
  logic [1:0]       mosi_s;
  logic [1:0]       rpin_s;
  logic [1:0]       rhost_s;
  logic [15:0]      rx_shift;
  logic [15:0]      tx_shift;
  logic [CNT_W-1:0] bit_cnt;
  logic             fault_sel;
  logic             miso_q;

  // two-stage synchronisers; the third sclk stage only feeds the edge detect
  always_ff @(posedge i_clock) begin
    sclk_s  <= {sclk_s[1:0], link.sclk};
    ce_s    <= {ce_s[0], link.ce_n};
    mosi_s  <= {mosi_s[0], link.mosi};
    rpin_s  <= {rpin_s[0], link.rst_pin_n};
    rhost_s <= {rhost_s[0], link.rst_host_oe};
  end

  wire sclk_rise   = sclk_s[1] & ~sclk_s[2];
  wire ce_low      = ~ce_s[1];
  // only an outside pull counts as a reset request, not our own fault pull
  wire ext_reset   = ~rpin_s[1] & rhost_s[1];                          // [RULE12]
  wire soft_rst    = i_rst | ext_reset;
  wire last_edge   = sclk_rise & ce_low & (bit_cnt == CNT_W'(FRAME_BITS - 1));
  wire [15:0] word = {rx_shift[14:0], mosi_s[1]};
  // conversion frame: result plus encoder; fault frame: flags plus encoder
  wire [15:0] conv_frame  = {1'b0, 3'h0, i_conv_result, i_encoder};    // [RULE11]
  wire [15:0] fault_frame = {1'b1, 7'h00, i_fault_flags, i_encoder};   // [RULE11]
  wire [15:0] load_frame  = fault_sel ? fault_frame : conv_frame;      // [RULE10]

  // serial engine; receive and transmit move on the same edge
  always_ff @(posedge i_clock) begin
    if (soft_rst) begin
      rx_shift <= 16'h0000;
      tx_shift <= 16'h0000;
      bit_cnt  <= '0;
    end else if (sclk_rise) begin
      if (!ce_low) begin
        tx_shift <= load_frame;                                        // [RULE1]
        bit_cnt  <= '0;                                                // [RULE19]
      end else begin
        rx_shift <= word;                                              // [RULE4] [RULE16]
        tx_shift <= {tx_shift[14:0], 1'b0};                            // [RULE2] [RULE16]
        if (bit_cnt != CNT_W'(FRAME_BITS))
          bit_cnt <= bit_cnt + CNT_W'(1);
      end
    end
  end

  // command registers change only on a complete sixteenth edge
  always_ff @(posedge i_clock) begin
    if (soft_rst) begin
      o_normal  <= NORMAL_RESET;                                       // [RULE12]
      o_config  <= CONFIG_RESET;
      fault_sel <= 1'b0;
    end else if (last_edge) begin                                      // [RULE5] [RULE19]
      if (word[DEST_BIT])
        o_config <= word;                                              // [RULE6] [RULE17]
      else
        o_normal <= word;                                              // [RULE6] [RULE17]
      fault_sel <= word[NRM_FAULT_SEL] & ~word[DEST_BIT];              // [RULE10]
    end
  end

  // miso data registered; tristated while the host holds the reset pin or i_rst is high
  always_ff @(posedge i_clock) begin
    if (i_rst)
      miso_q <= 1'b0;
    else
      miso_q <= tx_shift[FRAME_BITS-1];
  end
  assign link.miso_o     = miso_q;
  assign link.miso_oe    = ~ext_reset & ~i_rst;                        // [RULE12]
  assign link.rst_dev_oe = i_supply_undervoltage_lockout | i_reg_undervoltage_lockout | i_current_limit | i_thermal_shutdown; // [RULE13]

  // drive outputs: direction from register, switching from pulse pins
  function automatic logic [1:0] bridge(input logic dir, input logic pulse);
    bridge = pulse ? (dir ? 2'h2 : 2'h1) : 2'h0;
  endfunction
  assign o_bridge_a      = bridge(o_normal[NRM_DIR_A], bridge_a_pulse_in);        // [RULE14]
  assign o_bridge_b      = bridge(o_normal[NRM_DIR_B], bridge_b_pulse_in);        // [RULE14]
  // step outputs forced off during a reset pin request
  assign o_driver_c      = ext_reset ? 2'h0 :
                           {driver_c_pulse_in_b, driver_c_pulse_in_a} & {2{o_normal[NRM_DIR_C]}}; // [RULE14]
  assign o_low_side_hold = ext_reset;                                  // [RULE12]
  assign o_gate_drive    = o_config[CFG_GATE_EN];                      // [RULE15]
endmodule

/* core/mdsp_host.sv */
// Purpose: host end; sends one 16-bit word per command, collects the reply
// Assumes: software port with one-cycle strobes, read data one cycle later
// Notes:   sclk is divided from i_clock and runs free between frames
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module mdsp_host
  import mdsp_pkg::*;
#(
  parameter int DIV = LINK_DIV
)(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  mdsp_link_if.host        link,
  input  wire logic [1:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_write,
  input  wire logic        i_read,
  input  wire logic        i_reset_req,
  output logic [15:0]      o_rdata,
  output logic             o_busy,
  output logic             o_irq
);
  typedef enum {IDLE, PRE, SHIFT, GAP} state_t;
  state_t      state;
  logic [7:0]  div_cnt;
  logic        sclk;
  logic [15:0] tx;
  logic [15:0] rx;
  logic [4:0]  cnt;
  logic [15:0] rxdata;
  logic [1:0]  status;
  logic [1:0]  mask;
  logic [1:0]  miso_s;
  logic [2:0]  rpin_s;
  logic        ce_n;

  // host changes data on falling sclk, device samples on rising
  wire fall  = sclk & (div_cnt == 8'(DIV/2 - 1));
  wire rise  = ~sclk & (div_cnt == 8'(DIV/2 - 1));
  wire start = i_write & (i_addr == ADDR_CTRL) & (state == IDLE);
  wire done  = rise & (state == SHIFT) & (cnt == 5'd15);
  wire rst_edge = ~rpin_s[1] & rpin_s[2];

  always_ff @(posedge i_clock) begin
    miso_s <= {miso_s[0], link.miso};
    rpin_s <= {rpin_s[1:0], link.rst_pin_n};
  end

  // free-running link clock divider [RULE9] [RULE18]
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      div_cnt <= 8'h00;
      sclk    <= 1'b0;
    end else if (div_cnt == 8'(DIV/2 - 1)) begin
      div_cnt <= 8'h00;
      sclk    <= ~sclk;
    end else
      div_cnt <= div_cnt + 8'h01;
  end

  // frame sequencer: one high-ce edge, sixteen low-ce edges
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= IDLE;
      ce_n  <= 1'b1;
      tx    <= 16'h0000;
      rx    <= 16'h0000;
      cnt   <= 5'd0;
    end else begin
      case (state)
        IDLE: if (start) begin
          tx    <= i_wdata;
          state <= PRE;
        end
        PRE: if (rise) state <= GAP;                                   // [RULE8]
        GAP: if (fall) begin
          ce_n  <= 1'b0;
          cnt   <= 5'd0;
          state <= SHIFT;
        end
        SHIFT: begin
          if (rise) begin
            rx  <= {rx[14:0], miso_s[1]};
            cnt <= cnt + 5'd1;
          end
          if (fall && cnt != 5'd0)
            tx <= {tx[14:0], 1'b0};
          if (fall && cnt == 5'd16) begin                              // [RULE3]
            ce_n  <= 1'b1;
            tx    <= 16'h0000;                                         // [RULE7]
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // registers: reply capture and sticky status, set beats clear
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rxdata  <= 16'h0000;
      status  <= 2'h0;
      mask    <= 2'h0;
      o_rdata <= 16'h0000;
    end else begin
      if (done)
        rxdata <= {rx[14:0], miso_s[1]};
      if (i_write && i_addr == ADDR_MASK)
        mask <= i_wdata[1:0];
      status <= (status & ~((i_write && i_addr == ADDR_STATUS) ? i_wdata[1:0] : 2'h0))
                | {rst_edge, done};
      if (i_read) begin
        case (i_addr)
          ADDR_CTRL:   o_rdata <= {15'h0000, o_busy};
          ADDR_STATUS: o_rdata <= {14'h0000, status};
          ADDR_MASK:   o_rdata <= {14'h0000, mask};
          default:     o_rdata <= rxdata;
        endcase
      end
    end
  end

  assign link.sclk        = sclk;
  assign link.ce_n        = ce_n;
  // mosi held low whenever ce is high, so a loaded word never shows early
  assign link.mosi        = ~ce_n & tx[15];                          // [RULE7]
  assign link.rst_host_oe = i_reset_req;
  assign o_busy           = (state != IDLE);
  assign o_irq            = |(status & mask);
endmodule

/* core/mdsp_link_if.sv */
// Purpose: serial link between host controller and device port
// Assumes: reset line is open drain with a pull-up
// Notes:   tristate resolution for miso and the reset line lives here
`timescale 1ns/100ps
interface mdsp_link_if;
  logic sclk;
  logic ce_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic rst_host_oe;
  logic rst_dev_oe;
  wire  miso      = miso_oe ? miso_o : 1'b0;
  wire  rst_pin_n = ~(rst_host_oe | rst_dev_oe);
  modport device (input sclk, input ce_n, input mosi, input rst_pin_n, input rst_host_oe,
                  output miso_o, output miso_oe, output rst_dev_oe);
  modport host   (output sclk, output ce_n, output mosi, output rst_host_oe,
                  input miso, input rst_pin_n);
endinterface

/* core/mdsp_pkg.sv */
// Purpose: shared constants for the motor driver serial control port
// Assumes: 16-bit frames, msb first, link clock sampled by i_clock
// Notes:   field positions inside the two command words are chosen here
package mdsp_pkg;
  localparam int FRAME_BITS      = 16;
  localparam int CNT_W           = 5;
  // command word field positions (bit 0 is the destination select)
  localparam int DEST_BIT        = 0;
  localparam int NRM_FAULT_SEL   = 1;
  localparam int NRM_DIR_A       = 2;
  localparam int NRM_DIR_B       = 3;
  localparam int NRM_DIR_C       = 4;
  localparam int CFG_GATE_EN     = 1;
  localparam logic [15:0] NORMAL_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  // host side timing
  localparam int CLOCK_MHZ       = 25;
  // eight clocks per sclk: the device sync plus the miso return path take six clocks
  localparam int LINK_DIV        = 8;
  // host status / interrupt register layout
  localparam logic [1:0] ADDR_CTRL   = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_MASK   = 2'h2;
  localparam logic [1:0] ADDR_RXDATA = 2'h3;
  localparam int ST_DONE         = 0;
  localparam int ST_RESET_SEEN   = 1;
endpackage

/* test/mdsp_link_properties.sv */
// Purpose: link-level checks between the host and device ends
// Assumes: sclk, ce_n and mosi are sampled by i_clock
// Notes:   rise counts lag the wire by one sample, so edges seen here are late but ordered
`timescale 1ns/100ps
module mdsp_link_properties (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic sclk,
  input wire logic ce_n,
  input wire logic mosi,
  input wire logic miso_oe,
  input wire logic rst_host_oe
);
  logic       sclk_q;
  logic [4:0] lo_cnt;
  logic [1:0] hi_cnt;
  wire        rise = sclk & ~sclk_q;
  // rises inside a frame, and saturating rises ahead of it
  always_ff @(posedge i_clock) begin
    sclk_q <= sclk;
    lo_cnt <= (i_rst | ce_n) ? 5'h00 : lo_cnt + {4'h0, rise};
    hi_cnt <= (i_rst | ~ce_n) ? 2'h0 : hi_cnt + {1'b0, rise & (hi_cnt != 2'h3)};
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // idle level tolerates one sample after ce rises at each frame end
  mosi_idle_a:   assert property (ce_n [*2] |-> !mosi) else $error("mosi high while idle");
  frame_len_a:   assert property ($rose(ce_n) |-> lo_cnt == 5'h10) else $error("frame not 16 rises");
  no_overrun_a:  assert property (!ce_n |-> lo_cnt <= 5'h10) else $error("rises past sixteen");
  lead_edge_a:   assert property ($fell(ce_n) |-> hi_cnt != 2'h0) else $error("no rise before frame");
  sclk_runs_a:   assert property (1'b1 |-> ##[1:6] $changed(sclk)) else $error("sclk stopped");
  sclk_rate_a:   assert property ($changed(sclk) |=> $stable(sclk)) else $error("sclk too fast");
  ce_on_low_a:   assert property ($changed(ce_n) |-> !sclk) else $error("ce moved while sclk high");
  mosi_hold_a:   assert property (rise && !ce_n |-> $stable(mosi)) else $error("mosi moved at rise");
  pin_tristate_a: assert property (rst_host_oe [*5] |-> !miso_oe) else $error("miso driven in reset");
  cover property ($fell(ce_n));
  cover property ($rose(ce_n) && lo_cnt == 5'h10);
  cover property (rst_host_oe [*5]);
endmodule

/* test/testbench.sv */
// Purpose: self-checking bench joining the host and device ends
// Assumes: host map ctrl, status, mask, reply; default divider
// Notes:   replies are checked only after a normal word, where the select bit is unambiguous
`timescale 1ns/100ps
module testbench;
  import mdsp_pkg::*;
  logic        i_clock, i_rst, i_write, i_read, i_reset_req, o_busy, o_irq, o_low_side_hold, o_gate_drive;
  logic [1:0]  i_addr, o_bridge_a, o_bridge_b, drv_c;
  logic [3:0]  enc, flt, faults, pulses;
  logic [7:0]  conv;
  logic [15:0] i_wdata, o_rdata, o_normal, o_config, rd, lf, prev, word, exp_n, exp_c;
  int          mismatches, compares;
  mdsp_link_if link ();
  mdsp_host i_mdsp_host (.i_clock, .i_rst, .link(link.host), .i_addr, .i_wdata, .i_write, .i_read,
    .i_reset_req, .o_rdata, .o_busy, .o_irq);
  mdsp_device i_mdsp_device (.i_clock, .i_rst, .link(link.device), .i_conv_result(conv), .i_encoder(enc),
    .i_fault_flags(flt), .i_supply_undervoltage_lockout(faults[0]), .i_reg_undervoltage_lockout(faults[1]), .i_current_limit(faults[2]),
    .i_thermal_shutdown(faults[3]), .bridge_a_pulse_in(pulses[0]), .bridge_b_pulse_in(pulses[1]),
    .driver_c_pulse_in_a(pulses[2]), .driver_c_pulse_in_b(pulses[3]), .o_bridge_a, .o_bridge_b,
    .o_driver_c(drv_c), .o_low_side_hold, .o_gate_drive, .o_normal, .o_config);
  mdsp_link_properties i_mdsp_link_properties (.i_clock, .i_rst, .sclk(link.sclk), .ce_n(link.ce_n),
    .mosi(link.mosi), .miso_oe(link.miso_oe), .rst_host_oe(link.rst_host_oe));
  // expectation helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] frame(input logic sel);
    return sel ? {1'b1, 7'h00, flt, enc} : {4'h0, conv, enc};
  endfunction
  function automatic logic [15:0] bridge(input logic p, input logic d);
    return {14'h0, p ? (d ? 2'h2 : 2'h1) : 2'h0};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // software port cycles: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_addr  <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a);
    @(posedge i_clock);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 rd = o_rdata;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    @(posedge i_clock);
    #1;
    while (o_busy !== 1'b0 && n < 400) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    if (n == 400) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // frames first, then device faults, then a host-driven reset pin
  initial begin
    {i_rst, i_write, i_read, i_reset_req} = 4'h8;
    {i_addr, i_wdata, conv, enc, flt, faults, pulses} = '0;
    {prev, exp_n, exp_c} = '0;
    lf = 16'h5253;
    mismatches = 0;
    compares = 0;
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    #1;
    chk("normal", NORMAL_RESET, o_normal);
    chk("config", CONFIG_RESET, o_config);
    for (int k = 0; k < 12; k++) begin
      @(posedge i_clock);
      {conv, enc, flt} <= lf;
      pulses <= lf[15:12];
      lf = lfsr(lf);
      word = k == 0 ? 16'h0002 : k == 1 ? 16'hffff : k == 2 ? 16'hfffe : lf;
      wr(ADDR_CTRL, word);
      wait_idle();
      repeat (4) @(posedge i_clock);
      #1;
      if (word[DEST_BIT]) exp_c = word;
      else exp_n = word;
      chk("normal", exp_n, o_normal);
      chk("config", exp_c, o_config);
      chk("gate", {15'h0, exp_c[CFG_GATE_EN]}, {15'h0, o_gate_drive});
      chk("bridge a", bridge(pulses[0], exp_n[NRM_DIR_A]), {14'h0, o_bridge_a});
      chk("bridge b", bridge(pulses[1], exp_n[NRM_DIR_B]), {14'h0, o_bridge_b});
      chk("driver c", {14'h0, pulses[3:2] & {2{exp_n[NRM_DIR_C]}}}, {14'h0, drv_c});
      rd_reg(ADDR_RXDATA);
      if (!prev[DEST_BIT]) chk("reply", frame(prev[NRM_FAULT_SEL]), rd);
      prev = word;
    end
    rd_reg(ADDR_STATUS);
    chk("done", 16'h0001, {15'h0, rd[ST_DONE]});
    wr(ADDR_STATUS, 16'h0003);
    for (int f = 0; f < 4; f++) begin
      faults <= 4'h1 << f;
      repeat (3) @(posedge i_clock);
      #1;
      chk("pin", 16'h0, {15'h0, link.rst_pin_n});
      chk("masked irq", 16'h0, {15'h0, o_irq});
      faults <= 4'h0;
      rd_reg(ADDR_STATUS);
      chk("pin event", 16'h0001, {15'h0, rd[ST_RESET_SEEN]});
      wr(ADDR_STATUS, 16'h0002);
    end
    wr(ADDR_MASK, 16'h0002);
    i_reset_req <= 1'b1;
    repeat (6) @(posedge i_clock);
    #1;
    chk("normal", NORMAL_RESET, o_normal);
    chk("config", CONFIG_RESET, o_config);
    chk("low side", 16'h0001, {15'h0, o_low_side_hold});
    chk("driver c off", 16'h0, {14'h0, drv_c});
    i_reset_req <= 1'b0;
    repeat (4) @(posedge i_clock);
    #1;
    chk("irq", 16'h0001, {15'h0, o_irq});
    wr(ADDR_STATUS, 16'h0002);
    @(posedge i_clock);
    #1;
    chk("irq", 16'h0, {15'h0, o_irq});
    tally_and_finish();
  end
endmodule
